// ==== uff_map.svh ====
// Register map, field positions and reset values of the flow-control block.
// Assumes a 32-bit APB slave decoding byte addresses on the low address bits.
`ifndef UFF_MAP_SVH
`define UFF_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices and byte offsets
// ----------------------------------------------------------------------------
`define UFF_IX_EFR 4'h0
`define UFF_IX_RES1 4'h1
`define UFF_IX_RES2 4'h2
`define UFF_IX_PAU1 4'h3
`define UFF_IX_PAU2 4'h4
`define UFF_IX_IER 4'h5
`define UFF_IX_FCR 4'h6
`define UFF_IX_MCR 4'h7
`define UFF_IX_FRAC 4'h8
`define UFF_IX_DIVL 4'h9
`define UFF_IX_DIVH 4'ha
`define UFF_IX_MSR 4'hb
`define UFF_IX_STAT 4'hc
`define UFF_IX_NONE 4'hf
`define UFF_ADDR_W 8
`define UFF_IX_LSB 2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UFF_EFR_ENH 4
`define UFF_EFR_SPECIAL 5
`define UFF_EFR_ARTS 6
`define UFF_EFR_ACTS 7
`define UFF_MCR_DTR 0
`define UFF_MCR_RTS 1
`define UFF_IER_TRIG 0
`define UFF_IER_PAUSE 4
`define UFF_IER_SPECIAL 5
`define UFF_ST_PAUSED 0
`define UFF_ST_RTSHOLD 1
`define UFF_ST_TRIG 2
`define UFF_ST_SPECIAL 4
`define UFF_ST_PAUSE 5
`define UFF_ST_W1C 8'h34

// ----------------------------------------------------------------------------
// Gate masks and reset values
// ----------------------------------------------------------------------------
`define UFF_GATE_IER 8'hf0
`define UFF_GATE_FCR 8'h30
`define UFF_GATE_MCR 8'he0
`define UFF_GATE_ST 8'h30
`define UFF_GATE_ALL 8'hff
`define UFF_RST_BYTE 8'h00
`define UFF_PWR_DIVL 8'h01
`define UFF_PWR_DIVH 8'h00
`define UFF_HYST_DEF 4

`endif

// ==== uff_pkg.sv ====
// Types shared by the flow-control block.
// Assumes uff_map.svh supplies the numeric constants.
package uff_pkg;

	// Character match mode of one resume or pause detector
	typedef enum logic [4:0] {
		MM_OFF = 5'b00001,
		MM_FIRST = 5'b00010,
		MM_SECOND = 5'b00100,
		MM_EITHER = 5'b01000,
		MM_PAIR = 5'b10000
	} uff_match_e;

	// Transmit flow character sender
	typedef enum logic [2:0] {
		FC_IDLE = 3'b001,
		FC_FIRST = 3'b010,
		FC_SECOND = 3'b100
	} uff_fc_e;

endpackage

// ==== uff_seq_match.sv ====
// One in-band character detector: single, either-of-two or two-in-a-row match.
// Assumes received characters arrive as one-cycle strobes on the system clock.
`timescale 1ns/10ps
module uff_seq_match (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic char_valid_i,
	input wire logic [7:0] char_i,
	input wire logic [7:0] first_i,
	input wire logic [7:0] second_i,
	input wire uff_pkg::uff_match_e mode_i,
	output logic hit_o
);

	logic half;
	logic next_half;
	logic next_hit;
	wire eq_first = (char_i == first_i);
	wire eq_second = (char_i == second_i);

	// Match decode per mode; pair mode needs first char on the previous strobe
	always_comb begin
		next_hit = 1'b0;
		case (mode_i)
			uff_pkg::MM_FIRST: next_hit = char_valid_i && eq_first;
			uff_pkg::MM_SECOND: next_hit = char_valid_i && eq_second;
			uff_pkg::MM_EITHER: next_hit = char_valid_i && (eq_first || eq_second);
			uff_pkg::MM_PAIR: next_hit = char_valid_i && half && eq_second;
			default: next_hit = 1'b0;
		endcase
	end

	// Any other character breaks a pending pair
	assign next_half = char_valid_i ? ((mode_i == uff_pkg::MM_PAIR) && eq_first) : half;

	// Pair progress and hit strobe
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			half <= 1'b0;
			hit_o <= 1'b0;
		end else begin
			half <= next_half;
			hit_o <= next_hit;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_pair_needs_first: assert property (
		(mode_i == uff_pkg::MM_PAIR) && char_valid_i && eq_second && !half |=> !hit_o)
		else $error("Pair hit without preceding first character");

endmodule

// ==== uff_top.sv ====
// Enhanced feature and flow-control logic of one serial channel, APB register side.
// Assumes receiver, transmitter and FIFOs are outside and run on CLK_SYS_I.
`timescale 1ns/10ps
`include "uff_map.svh"
module uff_top #(
	parameter int LEVEL_W = 6,
	parameter logic [LEVEL_W-1:0] HYST = LEVEL_W'(`UFF_HYST_DEF)
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	input wire logic POWER_ON_RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [`UFF_ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic RX_CHAR_VALID_I,
	input wire logic [7:0] RX_CHAR_I,
	output logic RX_FIFO_VALID_O,
	output logic [7:0] RX_FIFO_DATA_O,
	input wire logic [LEVEL_W-1:0] RX_LEVEL_I,
	input wire logic [LEVEL_W-1:0] RX_TRIG_I,
	output logic TX_FC_VALID_O,
	output logic [7:0] TX_FC_DATA_O,
	input wire logic TX_FC_READY_I,
	output logic TX_ALLOW_O,
	input wire logic TX_SER_I,
	output logic TX_SER_O,
	input wire logic TX_FIFO_FULL_I,
	input wire logic CTS_N_I,
	input wire logic DSR_N_I,
	input wire logic RI_N_I,
	input wire logic CD_N_I,
	input wire logic INTERRUPT_OUTPUT_SELECT_I,
	output logic RTS_N_O,
	output logic DTR_N_O,
	output logic RECEIVE_READY_N_O,
	output logic TRANSMIT_READY_N_O,
	output logic INT_O,
	output logic INT_OE_N_O,
	output logic [15:0] DIVISOR_O,
	output logic [7:0] FRAC_DIV_O
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Address to register index; anything unmapped gives the none index
	function automatic logic [3:0] dec_index(input logic [`UFF_ADDR_W-1:0] a);
		logic [3:0] ix;
		ix = `UFF_IX_NONE;
		if (a[`UFF_IX_LSB-1:0] != '0) begin
			ix = `UFF_IX_NONE;
		end else if (a[`UFF_ADDR_W-1:`UFF_IX_LSB] <= 6'(`UFF_IX_STAT)) begin
			ix = a[`UFF_IX_LSB+3:`UFF_IX_LSB];
		end else begin
			ix = `UFF_IX_NONE;
		end
		return ix;
	endfunction

	// Keep masked bits unless the enhanced enable is set
	function automatic logic [7:0] gated(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask, input logic en);
		return en ? new_v : ((new_v & ~mask) | (old_v & mask));
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [4:0] pin_meta;
	logic [4:0] pin_s;
	logic [3:0] modem_prev;

	// No reset so the pin levels are visible while reset is held
	always_ff @(posedge CLK_SYS_I) begin
		pin_meta <= {INTERRUPT_OUTPUT_SELECT_I, CD_N_I, RI_N_I, DSR_N_I, CTS_N_I};
		pin_s <= pin_meta;
		modem_prev <= pin_s[3:0];
	end

	wire cts_s = pin_s[0];
	wire interrupt_output_select_s = pin_s[4];

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire [3:0] ix = dec_index(PADDR_I);
	wire mapped = (ix != `UFF_IX_NONE);
	wire access = PSEL_I && PENABLE_I;
	wire wr = access && PWRITE_I && mapped;
	wire rd_done = access && !PWRITE_I && (ix == `UFF_IX_MSR);
	wire [7:0] wd = PWDATA_I[7:0];

	assign PREADY_O = 1'b1;
	assign PSLVERR_O = access && !mapped;

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [7:0] enhanced_feature_control;
	logic [7:0] res1;
	logic [7:0] res2;
	logic [7:0] pau1;
	logic [7:0] pau2;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] fifo_control_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] frac;
	logic [7:0] divl;
	logic [7:0] divh;
	logic [3:0] delta;
	logic [7:0] status;
	wire enh = enhanced_feature_control[`UFF_EFR_ENH];

	// Plain and gated configuration registers; reset gives legacy behaviour
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			enhanced_feature_control <= `UFF_RST_BYTE;
			res1 <= `UFF_RST_BYTE;
			res2 <= `UFF_RST_BYTE;
			pau1 <= `UFF_RST_BYTE;
			pau2 <= `UFF_RST_BYTE;
			interrupt_enable_reg <= `UFF_RST_BYTE;
			fifo_control_reg <= `UFF_RST_BYTE;
			modem_control_reg <= `UFF_RST_BYTE;
			frac <= `UFF_RST_BYTE;
		end else if (wr) begin
			if (ix == `UFF_IX_EFR) enhanced_feature_control <= wd;
			if (ix == `UFF_IX_RES1) res1 <= wd;
			if (ix == `UFF_IX_RES2) res2 <= wd;
			if (ix == `UFF_IX_PAU1) pau1 <= wd;
			if (ix == `UFF_IX_PAU2) pau2 <= wd;
			if (ix == `UFF_IX_IER) interrupt_enable_reg <= gated(interrupt_enable_reg, wd, `UFF_GATE_IER, enh);
			if (ix == `UFF_IX_FCR) fifo_control_reg <= gated(fifo_control_reg, wd, `UFF_GATE_FCR, enh);
			if (ix == `UFF_IX_MCR) modem_control_reg <= gated(modem_control_reg, wd, `UFF_GATE_MCR, enh);
			if (ix == `UFF_IX_FRAC) frac <= gated(frac, wd, `UFF_GATE_ALL, enh);
		end
	end

	// Divisor bytes only know the power-up reset
	always_ff @(posedge CLK_SYS_I or posedge POWER_ON_RESET_I) begin
		if (POWER_ON_RESET_I) begin
			divl <= `UFF_PWR_DIVL;
			divh <= `UFF_PWR_DIVH;
		end else if (wr) begin
			if (ix == `UFF_IX_DIVL) divl <= wd;
			if (ix == `UFF_IX_DIVH) divh <= wd;
		end
	end

	assign DIVISOR_O = {divh, divl};
	assign FRAC_DIV_O = frac;

	// ------------------------------------------------------------------------
	// Modem status deltas; a change in the reading cycle survives the clear
	// ------------------------------------------------------------------------
	wire [3:0] chg = {pin_s[3] ^ modem_prev[3], pin_s[2] && !modem_prev[2],
		pin_s[1] ^ modem_prev[1], pin_s[0] ^ modem_prev[0]};
	wire [3:0] next_delta = (rd_done ? 4'h0 : delta) | chg;

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) delta <= 4'h0;
		else delta <= next_delta;
	end

	wire [7:0] modem_status_reg = {~pin_s[3:0], delta};

	// ------------------------------------------------------------------------
	// Receive side flow control and special character
	// ------------------------------------------------------------------------
	wire [1:0] rx_sel = enhanced_feature_control[1:0];
	wire [1:0] tx_sel = enhanced_feature_control[3:2];
	uff_pkg::uff_match_e rx_mode;

	// Receive match mode from the select bits
	always_comb begin
		rx_mode = uff_pkg::MM_OFF;
		if (rx_sel == 2'b10) rx_mode = uff_pkg::MM_FIRST;
		else if (rx_sel == 2'b01) rx_mode = uff_pkg::MM_SECOND;
		else if (rx_sel == 2'b11 && tx_sel == 2'b11) rx_mode = uff_pkg::MM_PAIR;
		else if (rx_sel == 2'b11) rx_mode = uff_pkg::MM_EITHER;
	end

	logic [1:0] hit;

	// Resume detector at 0, pause detector at 1
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_det
			uff_seq_match u_match (
				.clk_i(CLK_SYS_I),
				.rst_i(RESET_I),
				.char_valid_i(RX_CHAR_VALID_I),
				.char_i(RX_CHAR_I),
				.first_i(g == 0 ? res1 : pau1),
				.second_i(g == 0 ? res2 : pau2),
				.mode_i(rx_mode),
				.hit_o(hit[g])
			);
		end
	endgenerate

	wire special = RX_CHAR_VALID_I && enhanced_feature_control[`UFF_EFR_SPECIAL] && (RX_CHAR_I == pau2);
	wire drop = special && (rx_sel == 2'b01);
	logic paused;

	// Characters to the FIFO, held back only for a consumed second pause
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			RX_FIFO_VALID_O <= 1'b0;
			RX_FIFO_DATA_O <= `UFF_RST_BYTE;
		end else begin
			RX_FIFO_VALID_O <= RX_CHAR_VALID_I && !drop;
			RX_FIFO_DATA_O <= RX_CHAR_I;
		end
	end

	// Remote pause state; receive flow off releases it
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) paused <= 1'b0;
		else if (rx_sel == 2'b00) paused <= 1'b0;
		else if (hit[1]) paused <= 1'b1;
		else if (hit[0]) paused <= 1'b0;
	end

	// Transmitter gate; it finishes the character in flight itself
	assign TX_ALLOW_O = !paused && !(enhanced_feature_control[`UFF_EFR_ACTS] && cts_s);

	// ------------------------------------------------------------------------
	// Auto request-to-send with hysteresis
	// ------------------------------------------------------------------------
	wire [LEVEL_W:0] lvl = {1'b0, RX_LEVEL_I};
	wire [LEVEL_W:0] trig = {1'b0, RX_TRIG_I};
	wire [LEVEL_W:0] upper = trig + {1'b0, HYST};
	wire [LEVEL_W:0] lower = (RX_TRIG_I > HYST) ? trig - {1'b0, HYST} : '0;
	wire at_trig = (lvl >= trig);
	logic rts_hold;
	logic trig_prev;

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			rts_hold <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= at_trig;
			if (lvl >= upper) rts_hold <= 1'b1;
			else if (lvl < lower) rts_hold <= 1'b0;
		end
	end

	// Host must drive the modem bit active before auto mode can release it
	assign RTS_N_O = !modem_control_reg[`UFF_MCR_RTS] || (enhanced_feature_control[`UFF_EFR_ARTS] && rts_hold);
	assign DTR_N_O = !modem_control_reg[`UFF_MCR_DTR];

	// ------------------------------------------------------------------------
	// Sticky status; hardware set wins over write-one-to-clear
	// ------------------------------------------------------------------------
	wire [7:0] st_set = {2'b00, hit[1], special, 1'b0,
		enhanced_feature_control[`UFF_EFR_ARTS] && at_trig && !trig_prev, 2'b00};
	wire wr_st = wr && (ix == `UFF_IX_STAT);
	wire [7:0] st_clr = wr_st ? gated(8'h00, wd & `UFF_ST_W1C, `UFF_GATE_ST, enh) : 8'h00;

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) status <= `UFF_RST_BYTE;
		else status <= (status & ~st_clr) | st_set;
	end

	wire irq = (status[`UFF_ST_TRIG] && interrupt_enable_reg[`UFF_IER_TRIG])
		|| (status[`UFF_ST_PAUSE] && interrupt_enable_reg[`UFF_IER_PAUSE])
		|| (status[`UFF_ST_SPECIAL] && interrupt_enable_reg[`UFF_IER_SPECIAL]);

	// ------------------------------------------------------------------------
	// Transmit flow characters
	// ------------------------------------------------------------------------
	uff_pkg::uff_fc_e state;
	uff_pkg::uff_fc_e next_state;
	logic sent_pause;
	logic sending_pause;
	logic [7:0] next_fc_data;
	wire tx_on = (tx_sel != 2'b00);
	wire want_pause = tx_on && at_trig;
	wire [7:0] ch_first = want_pause ? pau1 : res1;
	wire [7:0] ch_second = sending_pause ? pau2 : res2;

	// Sender sequence: one character, or first then second of the pair
	always_comb begin
		next_state = state;
		next_fc_data = TX_FC_DATA_O;
		case (state)
			uff_pkg::FC_IDLE: begin
				if (tx_on && want_pause != sent_pause) begin
					next_state = uff_pkg::FC_FIRST;
					next_fc_data = (tx_sel == 2'b01) ? (want_pause ? pau2 : res2) : ch_first;
				end
			end
			uff_pkg::FC_FIRST: begin
				if (!tx_on) next_state = uff_pkg::FC_IDLE;
				else if (TX_FC_READY_I && tx_sel == 2'b11) begin
					next_state = uff_pkg::FC_SECOND;
					next_fc_data = ch_second;
				end else if (TX_FC_READY_I) next_state = uff_pkg::FC_IDLE;
			end
			uff_pkg::FC_SECOND: begin
				if (!tx_on || TX_FC_READY_I) next_state = uff_pkg::FC_IDLE;
			end
			default: next_state = uff_pkg::FC_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			state <= uff_pkg::FC_IDLE;
			TX_FC_DATA_O <= `UFF_RST_BYTE;
			sent_pause <= 1'b0;
			sending_pause <= 1'b0;
		end else begin
			state <= next_state;
			TX_FC_DATA_O <= next_fc_data;
			if (!tx_on) sent_pause <= 1'b0;
			else if (next_state == uff_pkg::FC_IDLE && state != uff_pkg::FC_IDLE)
				sent_pause <= sending_pause;
			if (state == uff_pkg::FC_IDLE) sending_pause <= want_pause;
		end
	end

	assign TX_FC_VALID_O = (state != uff_pkg::FC_IDLE);

	// ------------------------------------------------------------------------
	// Pin outputs and read data
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) begin
			TX_SER_O <= 1'b1;
			RECEIVE_READY_N_O <= 1'b1;
			TRANSMIT_READY_N_O <= 1'b0;
			INT_O <= 1'b0;
		end else begin
			TX_SER_O <= TX_SER_I;
			RECEIVE_READY_N_O <= (RX_LEVEL_I == '0);
			TRANSMIT_READY_N_O <= TX_FIFO_FULL_I;
			INT_O <= irq;
		end
	end

	// Floats unless the select strap asks for a driven output
	assign INT_OE_N_O = !interrupt_output_select_s;

	logic [7:0] rmux;

	// Read mux, captured in the setup phase
	always_comb begin
		case (ix)
			`UFF_IX_EFR: rmux = enhanced_feature_control;
			`UFF_IX_RES1: rmux = res1;
			`UFF_IX_RES2: rmux = res2;
			`UFF_IX_PAU1: rmux = pau1;
			`UFF_IX_PAU2: rmux = pau2;
			`UFF_IX_IER: rmux = interrupt_enable_reg;
			`UFF_IX_FCR: rmux = fifo_control_reg;
			`UFF_IX_MCR: rmux = modem_control_reg;
			`UFF_IX_FRAC: rmux = frac;
			`UFF_IX_DIVL: rmux = divl;
			`UFF_IX_DIVH: rmux = divh;
			`UFF_IX_MSR: rmux = modem_status_reg;
			`UFF_IX_STAT: rmux = {status[7:2], rts_hold, paused};
			default: rmux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
		if (RESET_I) PRDATA_O <= 32'h0000_0000;
		else if (PSEL_I && !PENABLE_I) PRDATA_O <= {24'h00_0000, rmux};
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);

	a_flow_off_idle: assert property (
		(enhanced_feature_control[3:0] == 4'h0) |=> (state == uff_pkg::FC_IDLE) && !paused)
		else $error("Flow control acted while all select bits were zero");

	sequence s_first_taken;
		(state == uff_pkg::FC_FIRST) && TX_FC_READY_I && (tx_sel == 2'b11);
	endsequence

	a_pair_second: assert property (
		s_first_taken |=> TX_FC_VALID_O && (TX_FC_DATA_O == (sending_pause ? pau2 : res2)))
		else $error("Second character of pair not offered after the first");

	a_special_drop: assert property (
		drop |=> !RX_FIFO_VALID_O && status[`UFF_ST_SPECIAL])
		else $error("Second pause reached the FIFO in mode 01");

	a_special_keep: assert property (
		special && (rx_sel != 2'b01) |=> RX_FIFO_VALID_O && status[`UFF_ST_SPECIAL])
		else $error("Special character lost or not flagged");

	a_gate_hold: assert property (
		wr && (ix == `UFF_IX_IER) && !enh |=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4]))
		else $error("Enhanced interrupt enable bits changed while latched");

	a_rts_deassert: assert property (
		enhanced_feature_control[`UFF_EFR_ARTS] && modem_control_reg[`UFF_MCR_RTS] && (lvl >= upper) ##1
		enhanced_feature_control[`UFF_EFR_ARTS] && modem_control_reg[`UFF_MCR_RTS] |-> RTS_N_O)
		else $error("Request-to-send still active above upper level");

	a_rts_reassert: assert property (
		(lvl < lower) ##1 enhanced_feature_control[`UFF_EFR_ARTS] && modem_control_reg[`UFF_MCR_RTS] |-> !RTS_N_O)
		else $error("Request-to-send not active below lower level");

	a_cts_stop: assert property (
		enhanced_feature_control[`UFF_EFR_ACTS] && cts_s |-> !TX_ALLOW_O)
		else $error("Transmit allowed while clear-to-send high");

	a_pause_halt: assert property (
		hit[1] && !hit[0] && (rx_sel != 2'b00) |=> !TX_ALLOW_O)
		else $error("Transmitter not halted after pause match");

endmodule

// ==== uff_remote.sv ====
// Remote serial device model: sends received characters, takes flow characters.
// Assumes one-cycle character strobes on the system clock of the flow-control block.
`timescale 1ns/10ps
module uff_remote (
	input wire logic clk_i,
	input wire logic send_i,
	input wire logic [7:0] byte_i,
	output logic rx_valid_o,
	output logic [7:0] rx_char_o,
	input wire logic fc_valid_i,
	input wire logic [7:0] fc_data_i,
	output logic fc_ready_o,
	output logic [15:0] fc_log_o
);
	// Start quiet, data line not yet meaningful
	initial begin
		rx_valid_o = 1'b0;
		rx_char_o = 8'h5a;
		fc_ready_o = 1'b0;
		fc_log_o = 16'h0000;
	end
	// Pair characters go out back to back, first then second idle data inverted
	always @(posedge clk_i) begin
		rx_valid_o <= send_i;
		rx_char_o <= send_i ? byte_i : ~rx_char_o;
	end
	// Accept flow characters only every other cycle, keep the last two
	always @(posedge clk_i) begin
		fc_ready_o <= ~fc_ready_o;
		if (fc_valid_i && fc_ready_o) begin
			fc_log_o <= {fc_log_o[7:0], fc_data_i};
		end
	end
endmodule

// ==== test_uff_top.sv ====
// Self-checking bench of the flow-control block against a remote device model.
// Assumes uff_map.svh, uff_pkg, uff_seq_match, uff_top and uff_remote compile first.
`timescale 1ns/10ps
module test_uff_top;
	logic clk = 0, rst = 1, por = 1, psel = 0, pen = 0, pwr = 0, snd = 0, ser = 1, full = 0;
	logic cts = 0, rxv, fcv, fifo_control_reg, allow, rts, dtr, tso, trn, rrn, fv, rdy, slv, err;
	logic ri = 1, interrupt_output_select = 1, irq, ioe;
	logic [7:0] pa = 0, sb = 0, rxc, fcd, frac, fd, fifo_last = 0;
	logic [31:0] pwd = 0, prd, r, lf = 32'h62dd6744;
	logic [5:0] lvl = 0;
	logic [15:0] div, fclog;
	logic [7:0] fifo_n = 0;
	int checked = 0, mismatches = 0, cycles = 0;

	uff_top uff_top_i (.CLK_SYS_I(clk), .RESET_I(rst), .POWER_ON_RESET_I(por), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(rdy), .PSLVERR_O(slv), .RX_CHAR_VALID_I(rxv), .RX_CHAR_I(rxc),
		.RX_FIFO_VALID_O(fv), .RX_FIFO_DATA_O(fd), .RX_LEVEL_I(lvl), .RX_TRIG_I(6'h08),
		.TX_FC_VALID_O(fcv), .TX_FC_DATA_O(fcd), .TX_FC_READY_I(fifo_control_reg), .TX_ALLOW_O(allow),
		.TX_SER_I(ser), .TX_SER_O(tso), .TX_FIFO_FULL_I(full), .CTS_N_I(cts), .DSR_N_I(1'b1),
		.RI_N_I(ri), .CD_N_I(1'b1), .INTERRUPT_OUTPUT_SELECT_I(interrupt_output_select), .RTS_N_O(rts), .DTR_N_O(dtr),
		.RECEIVE_READY_N_O(rrn), .TRANSMIT_READY_N_O(trn), .INT_O(irq), .INT_OE_N_O(ioe),
		.DIVISOR_O(div), .FRAC_DIV_O(frac));
	uff_remote uff_remote_i (.clk_i(clk), .send_i(snd), .byte_i(sb), .rx_valid_o(rxv),
		.rx_char_o(rxc), .fc_valid_i(fcv), .fc_data_i(fcd), .fc_ready_o(fifo_control_reg), .fc_log_o(fclog));

	always #50 clk = ~clk;
	// Next state of the random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Random serial bits, forwarded-character count and the hang limit
	always @(posedge clk) begin
		lf <= lfsr_next(lf);
		ser <= lf[0];
		full <= lf[1];
		if (fv === 1'b1) begin
			fifo_n <= fifo_n + 8'h01;
			fifo_last <= fd;
		end
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------------------
	function automatic logic [15:0] fexp(input logic [7:0] m, input logic p);
		logic [7:0] a;
		a = p ? 8'h13 : 8'h11;
		if (m[3] && m[2]) return {a, a + 8'h01};
		return {8'h00, a + 8'(m[2])};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		r = prd;
		err = slv;
		psel <= 1'b0;
		pen <= 1'b0;
		#1;
	endtask
	task automatic mode(input logic [7:0] m);
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h00, m);
	endtask
	task automatic send(input logic [7:0] c);
		@(posedge clk);
		snd <= 1'b1;
		sb <= c;
	endtask
	task automatic idle(input int k);
		@(posedge clk);
		snd <= 1'b0;
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic rx(input logic [7:0] c, input logic e);
		send(c);
		idle(5);
		chk(32'(allow), 32'(e));
	endtask
	task automatic give_verdict();
		$display("checked %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------------
	initial begin
		int i;
		logic [7:0] m, v;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		#1;
		chk(32'({rts, dtr, tso, trn, rrn, irq, ioe}), 32'h74);
		chk(32'(div), 32'h0001);
		for (i = 0; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 8'h00);
			chk(r, 32'h0);
		end
		apb(1'b0, 8'h2c, 8'h00);
		chk(r, 32'h10);
		ri <= 1'b0;
		idle(3);
		apb(1'b0, 8'h2c, 8'h00);
		chk(r, 32'h50);
		ri <= 1'b1;
		idle(3);
		apb(1'b0, 8'h2c, 8'h00);
		chk(r, 32'h14);
		for (i = 1; i < 5; i++) begin
			v = lf[7:0];
			apb(1'b1, 8'(4 * i), v);
			apb(1'b0, 8'(4 * i), 8'h00);
			chk(r, 32'(v));
		end
		apb(1'b0, 8'h3c, 8'h00);
		chk(32'({err, r[7:0]}), 32'h100);
		apb(1'b1, 8'h20, 8'ha5);
		chk(32'(frac), 32'h0);
		apb(1'b1, 8'h00, 8'h10);
		apb(1'b1, 8'h20, 8'ha5);
		apb(1'b1, 8'h24, 8'h37);
		chk(32'(frac), 32'ha5);
		rst <= 1'b1;
		interrupt_output_select <= 1'b0;
		idle(3);
		chk(32'({irq, ioe}), 32'h1);
		rst <= 1'b0;
		interrupt_output_select <= 1'b1;
		chk(32'({div, frac}), 32'h003700);
		for (i = 1; i < 5; i++) apb(1'b1, 8'(4 * i), 8'(8'h10 + i));
		// Receive matching in every mode
		mode(8'h02);
		rx(8'h13, 1'b0);
		rx(8'h11, 1'b1);
		rx(8'h14, 1'b1);
		mode(8'h01);
		rx(8'h14, 1'b0);
		rx(8'h12, 1'b1);
		mode(8'h0b);
		rx(8'h14, 1'b0);
		rx(8'h11, 1'b1);
		rx(8'h13, 1'b0);
		rx(8'h12, 1'b1);
		mode(8'h0f);
		rx(8'h14, 1'b1);
		send(8'h13);
		rx(8'h14, 1'b0);
		send(8'h11);
		rx(8'h12, 1'b1);
		mode(8'h80);
		cts <= 1'b1;
		idle(5);
		chk(32'(allow), 32'h0);
		cts <= 1'b0;
		idle(5);
		chk(32'(allow), 32'h1);
		// Special character in receive select modes 01 and 10
		mode(8'h31);
		m = fifo_n;
		rx(8'h14, 1'b0);
		apb(1'b0, 8'h30, 8'h00);
		chk(32'({fifo_n, r[5:4]}), 32'({m, 2'b11}));
		apb(1'b1, 8'h30, 8'h34);
		mode(8'h32);
		rx(8'h11, 1'b1);
		m = fifo_n;
		rx(8'h14, 1'b1);
		apb(1'b0, 8'h30, 8'h00);
		chk(32'({fifo_n, r[4]}), 32'({m + 8'h01, 1'b1}));
		chk(32'(fifo_last), 32'h14);
		// Transmit pause and resume characters per mode
		for (i = 0; i < 3; i++) begin
			m = (i == 0) ? 8'h08 : (i == 1) ? 8'h04 : 8'h0c;
			lvl <= 6'd0;
			mode(m);
			lvl <= 6'd8;
			idle(12);
			chk(32'(m == 8'h0c ? fclog : fclog[7:0]), 32'(fexp(m, 1'b1)));
			lvl <= 6'd0;
			idle(12);
			chk(32'(m == 8'h0c ? fclog : fclog[7:0]), 32'(fexp(m, 1'b0)));
		end
		// Automatic request-to-send with hysteresis
		apb(1'b1, 8'h1c, 8'h02);
		mode(8'h40);
		apb(1'b1, 8'h30, 8'h04);
		apb(1'b1, 8'h14, 8'h01);
		chk(32'({rts, irq}), 32'h0);
		lvl <= 6'd12;
		idle(3);
		chk(32'({rts, irq}), 32'h3);
		lvl <= 6'd4;
		idle(3);
		chk(32'(rts), 32'h1);
		lvl <= 6'd3;
		idle(3);
		chk(32'(rts), 32'h0);
		apb(1'b0, 8'h30, 8'h00);
		chk(32'(r[2]), 32'h1);
		give_verdict();
	end
endmodule
